// >>> src/fill_ecc_pkg.sv
package fill_ecc_pkg;
  // physical block address window kept on capture
  localparam int ADDR_HI = 42;
  localparam int ADDR_LO = 6;
  // top bit captured for a data-cache load error
  localparam int DC_ADDR_HI = 19;
  // per-quadword syndrome width
  localparam int SYND_W = 8;
  // octaword index width within a 64-byte block
  localparam int OCT_W = 2;
  // reset values
  localparam logic [SYND_W-1:0] SYND_RESET = 8'h00;
  localparam logic [ADDR_HI:ADDR_LO] ADDR_RESET = 37'h0;
  localparam logic [OCT_W-1:0] OCT_RESET = 2'h0;

  // what kind of access saw the error
  typedef enum logic [2:0] {
    SRC_IC_FILL,
    SRC_DC_FILL,
    SRC_VICTIM_MISS,
    SRC_VICTIM_EVICT,
    SRC_PROBE,
    SRC_DC_LOAD
  } err_src_t;

  // cache error status codes
  typedef enum logic [3:0] {
    STATUS_NONE,
    INSTR_FILL_BOARD_SINGLE,
    DATA_FILL_BOARD_SINGLE,
    INSTR_FILL_MEMORY_SINGLE,
    DATA_FILL_MEMORY_SINGLE,
    PROBE_HIT_SINGLE,
    DATA_CACHE_LOAD_SINGLE,
    INSTR_FILL_BOARD_DOUBLE,
    DATA_FILL_BOARD_DOUBLE,
    INSTR_FILL_MEMORY_DOUBLE,
    DATA_FILL_MEMORY_DOUBLE
  } status_code_t;

  localparam status_code_t STATUS_RESET = STATUS_NONE;
endpackage

// >>> src/scrub_if.sv
`timescale 1ns/1ps
// handshake between the error logger and the scrub sequencer
interface scrub_if;
  logic start; // one-cycle request, only while idle
  logic evict; // block goes to victim buffer
  logic writeBack; // block rewritten into data cache
  logic retry; // load queue retries the load
  logic busy; // sequence in progress
  modport ctrl(output start, input evict, input writeBack, input retry, input busy);
  modport seq(input start, output evict, output writeBack, output retry, output busy);
endinterface

// >>> src/load_scrub_seq.sv
`timescale 1ns/1ps
// evict, write back, then retry the load; one step per cycle
module load_scrub_seq (
  input wire logic sys_clk,
  input wire logic reset,
  scrub_if.seq sif
);
  typedef enum logic [1:0] {IDLE, EVICT, WRITE_BACK, RETRY} scrub_state_t;
  scrub_state_t state_r; // current step
  scrub_state_t state_nxt; // next step
  logic evict_r; // step strobes, registered
  logic writeBack_r;
  logic retry_r;

  // step order is fixed; a start while busy is never sent
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IDLE: if (sif.start) state_nxt = EVICT;
      EVICT: state_nxt = WRITE_BACK;
      WRITE_BACK: state_nxt = RETRY;
      RETRY: state_nxt = IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (reset) state_r <= IDLE;
    else state_r <= state_nxt;
  end

  // strobes line up with the step they name
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evict_r <= 1'b0;
      writeBack_r <= 1'b0;
      retry_r <= 1'b0;
    end else begin
      evict_r <= (state_nxt == EVICT);
      writeBack_r <= (state_nxt == WRITE_BACK);
      retry_r <= (state_nxt == RETRY);
    end
  end

  assign sif.evict = evict_r;
  assign sif.writeBack = writeBack_r;
  assign sif.retry = retry_r;
  assign sif.busy = (state_r != IDLE);
endmodule // load_scrub_seq

// >>> src/machine_check_pender.sv
`timescale 1ns/1ps
// holds a machine check while firmware mode is on
module machine_check_pender (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic post,
  input wire logic immediate,
  input wire logic firmwareMode,
  output logic take
);
  logic pending_r; // posted, not yet delivered
  logic take_r; // delivery pulse
  logic takeNow; // deliver this cycle

  // immediate posts bypass the firmware-mode hold
  assign takeNow = (post && immediate) || ((pending_r || post) && !firmwareMode);

  // pending flag; several posts merge into one delivery
  always_ff @(posedge sys_clk) begin
    if (reset) pending_r <= 1'b0;
    else pending_r <= (pending_r || post) && !takeNow;
  end

  // registered delivery pulse
  always_ff @(posedge sys_clk) begin
    if (reset) take_r <= 1'b0;
    else take_r <= takeNow;
  end

  assign take = take_r;
endmodule // machine_check_pender

// >>> src/fill_ecc_error_recovery.sv
`timescale 1ns/1ps
// What this block does
// - victim miss error: no fix, no status, interrupt
// - evict-block victim: raw out, nothing logged
// - instruction fill single: bad parity, flush
// - instruction fill: status and address captured
// - fill and probe singles store both syndromes
// - instruction fill single: immediate check plus interrupt
// - unused data fill word written raw, logged
// - load-used word: raw register write, queue held
// - replay trap, map stage stalled until corrected
// - scrub by evict then write back
// - retry load, set status, flag, interrupt
// - speculative load: interrupt only, no status
// - probe error: extract, interrupt, forward raw
// - probe: status, block address, syndromes
// - double fill: one of four status codes
// - double fill: check deferred in firmware mode
// - double memory fill written with original check
// - status stays accurate under fill traffic
// - data cache load: only low address bits
// - firmware-mode check held until native mode
module fill_ecc_error_recovery (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic errValid,
  input fill_ecc_pkg::err_src_t errSource,
  input wire logic errFromMemory,
  input wire logic errDouble,
  input wire logic errLoadUse,
  input wire logic errSpeculative,
  input wire logic [fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::ADDR_LO] errAddr,
  input wire logic [fill_ecc_pkg::SYND_W-1:0] errSynd0,
  input wire logic [fill_ecc_pkg::SYND_W-1:0] errSynd1,
  input wire logic [fill_ecc_pkg::OCT_W-1:0] errOctaword,
  input wire logic crdEnable,
  input wire logic mchkEnable,
  input wire logic firmwareMode,
  input wire logic statusClear,
  output logic correctedReadInterrupt,
  output logic machineCheck,
  output fill_ecc_pkg::status_code_t cacheErrorStatus,
  output logic [fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::ADDR_LO] errorAddress,
  output logic [fill_ecc_pkg::SYND_W-1:0] syndrome0,
  output logic [fill_ecc_pkg::SYND_W-1:0] syndrome1,
  output logic loadEccFlag,
  output logic icacheFlush,
  output logic badParityWrite,
  output logic [fill_ecc_pkg::OCT_W-1:0] badParityOctaword,
  output logic rawCacheWrite,
  output logic rawRegisterWrite,
  output logic loadQueueHold,
  output logic replayTrap,
  output logic mapStall,
  output logic scrubEvict,
  output logic scrubWriteBack,
  output logic loadRetry,
  output logic rawVictimToPort,
  output logic rawProbeForward
);
  // status code for a logged event
  function automatic fill_ecc_pkg::status_code_t statusOf(
    input fill_ecc_pkg::err_src_t src, input logic mem, input logic dbl);
    fill_ecc_pkg::status_code_t code;
    code = fill_ecc_pkg::STATUS_NONE;
    if (src == fill_ecc_pkg::SRC_PROBE) code = fill_ecc_pkg::PROBE_HIT_SINGLE;
    else if (src == fill_ecc_pkg::SRC_DC_LOAD) code = fill_ecc_pkg::DATA_CACHE_LOAD_SINGLE;
    else if (src == fill_ecc_pkg::SRC_IC_FILL)
      code = dbl ? (mem ? fill_ecc_pkg::INSTR_FILL_MEMORY_DOUBLE
                        : fill_ecc_pkg::INSTR_FILL_BOARD_DOUBLE)
                 : (mem ? fill_ecc_pkg::INSTR_FILL_MEMORY_SINGLE
                        : fill_ecc_pkg::INSTR_FILL_BOARD_SINGLE);
    else if (src == fill_ecc_pkg::SRC_DC_FILL)
      code = dbl ? (mem ? fill_ecc_pkg::DATA_FILL_MEMORY_DOUBLE
                        : fill_ecc_pkg::DATA_FILL_BOARD_DOUBLE)
                 : (mem ? fill_ecc_pkg::DATA_FILL_MEMORY_SINGLE
                        : fill_ecc_pkg::DATA_FILL_BOARD_SINGLE);
    return code;
  endfunction

  scrub_if sif(); // sequencer handshake

  // event decode, one event per cycle at most
  logic icFill; // instruction fill error
  logic dcFill; // data fill error
  logic victimMiss; // board victim on miss
  logic victimEvict; // board victim on evict-block
  logic probeHit; // probe hit error
  logic dcLoad; // data cache own error on load
  logic fillDouble; // uncorrectable fill
  logic icSingle; // correctable instruction fill
  logic loadFix; // needs replay and scrub
  logic specLoad; // speculative load, no scrub
  logic logStatus; // write status register
  logic fullAddr; // capture whole block address
  logic keepSynd; // capture syndromes
  logic crdPost; // interrupt condition, before enable
  logic mchkPost; // machine check condition, already gated by its enable
  logic scrubGo; // start accepted this cycle
  logic mchkTake; // from the pender

  assign icFill = errValid && (errSource == fill_ecc_pkg::SRC_IC_FILL);
  assign dcFill = errValid && (errSource == fill_ecc_pkg::SRC_DC_FILL);
  assign victimMiss = errValid && (errSource == fill_ecc_pkg::SRC_VICTIM_MISS);
  assign victimEvict = errValid && (errSource == fill_ecc_pkg::SRC_VICTIM_EVICT);
  assign probeHit = errValid && (errSource == fill_ecc_pkg::SRC_PROBE);
  assign dcLoad = errValid && (errSource == fill_ecc_pkg::SRC_DC_LOAD);
  assign fillDouble = (icFill || dcFill) && errDouble;
  assign icSingle = icFill && !errDouble;
  // a load needing the data: data fill used by a load, or own cache error
  assign specLoad = ((dcFill && !errDouble && errLoadUse) || dcLoad) && errSpeculative;
  assign loadFix = ((dcFill && !errDouble && errLoadUse) || dcLoad) && !errSpeculative;
  // victims and speculative loads never touch the status
  assign logStatus = icFill || (dcFill && !specLoad) || probeHit || (dcLoad && !specLoad);
  assign fullAddr = logStatus && !dcLoad;
  // the double flag only qualifies fills; a probe always keeps its syndromes
  assign keepSynd = logStatus && !fillDouble && !dcLoad;
  // doubles raise a check instead of the interrupt
  assign crdPost = icSingle || (dcFill && !errDouble) || victimMiss || probeHit || dcLoad;
  assign mchkPost = mchkEnable && (icSingle || fillDouble);
  // a second fixable load while busy is logged but not re-scrubbed
  assign scrubGo = loadFix && !sif.busy && !sif.start;

  // status register; a new event wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (reset) cacheErrorStatus <= fill_ecc_pkg::STATUS_RESET;
    else if (logStatus) cacheErrorStatus <= statusOf(errSource, errFromMemory, errDouble);
    else if (statusClear) cacheErrorStatus <= fill_ecc_pkg::STATUS_RESET;
  end

  // address capture; not cleared by software, only overwritten
  always_ff @(posedge sys_clk) begin
    if (reset) errorAddress <= fill_ecc_pkg::ADDR_RESET;
    else if (fullAddr) errorAddress <= errAddr;
    else if (dcLoad && !specLoad)
      errorAddress[fill_ecc_pkg::DC_ADDR_HI:fill_ecc_pkg::ADDR_LO] <=
        errAddr[fill_ecc_pkg::DC_ADDR_HI:fill_ecc_pkg::ADDR_LO];
  end

  // syndromes of both quadwords of the failing octaword
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syndrome0 <= fill_ecc_pkg::SYND_RESET;
      syndrome1 <= fill_ecc_pkg::SYND_RESET;
    end else if (keepSynd) begin
      syndrome0 <= errSynd0;
      syndrome1 <= errSynd1;
    end
  end

  // sticky load flag, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (reset) loadEccFlag <= 1'b0;
    else if (loadFix) loadEccFlag <= 1'b1;
    else if (statusClear) loadEccFlag <= 1'b0;
  end

  // interrupt pulse, gated only by its enable
  always_ff @(posedge sys_clk) begin
    if (reset) correctedReadInterrupt <= 1'b0;
    else correctedReadInterrupt <= crdPost && crdEnable;
  end

  // instruction cache side: poison octaword and flush everything in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      icacheFlush <= 1'b0;
      badParityWrite <= 1'b0;
      badParityOctaword <= fill_ecc_pkg::OCT_RESET;
    end else begin
      icacheFlush <= icSingle;
      badParityWrite <= icSingle;
      if (icSingle) badParityOctaword <= errOctaword;
    end
  end

  // raw writes keep original check bits so later readers see the error
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rawCacheWrite <= 1'b0;
      rawRegisterWrite <= 1'b0;
    end else begin
      rawCacheWrite <= (dcFill && !errDouble && !errLoadUse) ||
                       (fillDouble && errFromMemory);
      rawRegisterWrite <= dcFill && !errDouble && errLoadUse;
    end
  end

  // uncorrected forwards to the system port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rawVictimToPort <= 1'b0;
      rawProbeForward <= 1'b0;
    end else begin
      rawVictimToPort <= victimMiss || victimEvict;
      rawProbeForward <= probeHit;
    end
  end

  // replay trap on the load and scrub request, both in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      replayTrap <= 1'b0;
      sif.start <= 1'b0;
    end else begin
      replayTrap <= loadFix;
      sif.start <= scrubGo;
    end
  end

  // queue entry held until the retry, map stage until the write back
  always_ff @(posedge sys_clk) begin
    if (reset) loadQueueHold <= 1'b0;
    else if (scrubGo) loadQueueHold <= 1'b1;
    else if (sif.retry) loadQueueHold <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) mapStall <= 1'b0;
    else if (scrubGo) mapStall <= 1'b1;
    else if (sif.writeBack) mapStall <= 1'b0;
  end

  load_scrub_seq u_scrub (
    .sys_clk(sys_clk),
    .reset(reset),
    .sif(sif.seq)
  );

  // instruction fill singles are taken at once, doubles wait for native mode
  machine_check_pender u_machine_check (
    .sys_clk(sys_clk),
    .reset(reset),
    .post(mchkPost),
    .immediate(icSingle),
    .firmwareMode(firmwareMode),
    .take(mchkTake)
  );

  assign machineCheck = mchkTake;
  assign scrubEvict = sif.evict;
  assign scrubWriteBack = sif.writeBack;
  assign loadRetry = sif.retry;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_VICTIM_MISS: assert property (victimMiss && !statusClear |=>
    cacheErrorStatus == $past(cacheErrorStatus) && correctedReadInterrupt == $past(crdEnable))
    else $error("victim miss changed status or lost interrupt");
  AST_EVICT_SILENT: assert property (victimEvict && !statusClear |=>
    !correctedReadInterrupt && rawVictimToPort && $stable(cacheErrorStatus))
    else $error("evict-block victim was not silent");
  AST_IC_FLUSH: assert property (icSingle |=>
    icacheFlush && badParityWrite && badParityOctaword == $past(errOctaword))
    else $error("instruction fill error without flush");
  AST_IC_CAPTURE: assert property (icFill |=>
    cacheErrorStatus == statusOf($past(errSource), $past(errFromMemory), $past(errDouble))
    && errorAddress == $past(errAddr))
    else $error("instruction fill status or address wrong");
  AST_PROBE_SYND: assert property (probeHit |=>
    syndrome0 == $past(errSynd0) && syndrome1 == $past(errSynd1) && rawProbeForward
    && cacheErrorStatus == fill_ecc_pkg::PROBE_HIT_SINGLE)
    else $error("probe capture wrong");
  AST_IC_MACHINE_CHECK: assert property (icSingle && mchkEnable |=> machineCheck)
    else $error("instruction fill check not immediate");
  AST_RAW_UNUSED: assert property (dcFill && !errDouble && !errLoadUse |=>
    rawCacheWrite && correctedReadInterrupt == $past(crdEnable))
    else $error("unused fill word not written raw");
  AST_SCRUB_SEQ: assert property (sif.start |=>
    scrubEvict && mapStall ##1 scrubWriteBack ##1 loadRetry && !mapStall ##1 !loadQueueHold)
    else $error("scrub sequence out of order");
  AST_SPEC_NO_STATUS: assert property (specLoad && !statusClear |=>
    $stable(cacheErrorStatus) && $stable(errorAddress) && !replayTrap)
    else $error("speculative load was logged or scrubbed");
  AST_DC_LOAD_ADDR: assert property (dcLoad && !specLoad |=>
    errorAddress[fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::DC_ADDR_HI+1] ==
    $past(errorAddress[fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::DC_ADDR_HI+1]))
    else $error("high address bits changed on load error");
  AST_MACHINE_CHECK_DEFER: assert property (fillDouble && mchkEnable && firmwareMode
    ##1 firmwareMode |-> !machineCheck)
    else $error("double-fill check taken in firmware mode");
  AST_LOAD_REPLAY: assert property (loadFix |=> replayTrap && loadEccFlag)
    else $error("fixable load without replay or flag");

  COV_IC_FILL: cover property (icSingle && crdEnable && mchkEnable ##1 machineCheck);
  COV_SCRUB: cover property (sif.start ##3 loadRetry);
  COV_DEFERRED: cover property (fillDouble && mchkEnable && firmwareMode ##[1:8] machineCheck);
  COV_PROBE: cover property (probeHit ##1 correctedReadInterrupt);
endmodule // fill_ecc_error_recovery

// >>> tb/fill_source_model.sv
`timescale 1ns/1ps
// far side: memory, board cache and other processors presenting one error per request
module fill_source_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic send,
  input fill_ecc_pkg::err_src_t srcIn,
  input wire logic [3:0] flagsIn,
  input wire logic [fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::ADDR_LO] addrIn,
  input wire logic [17:0] dataIn,
  output logic errValid,
  output fill_ecc_pkg::err_src_t errSource,
  output logic errFromMemory,
  output logic errDouble,
  output logic errLoadUse,
  output logic errSpeculative,
  output logic [fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::ADDR_LO] errAddr,
  output logic [7:0] errSynd0,
  output logic [7:0] errSynd1,
  output logic [1:0] errOctaword
);
  // one-cycle strobe for each request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errValid <= 1'b0;
    end else begin
      errValid <= send;
    end
  end

  // qualifiers are only meaningful with the strobe; elsewhere address, syndromes and octaword show inverted junk
  always_ff @(posedge sys_clk) begin
    if (send) begin
      errSource <= srcIn;
      {errFromMemory, errDouble, errLoadUse, errSpeculative} <= flagsIn;
      errAddr <= addrIn;
      {errSynd0, errSynd1, errOctaword} <= dataIn;
    end else if (reset) begin
      errSource <= fill_ecc_pkg::SRC_IC_FILL;
      {errFromMemory, errDouble, errLoadUse, errSpeculative} <= 4'h0;
      errAddr <= '0;
      {errSynd0, errSynd1, errOctaword} <= 18'h00000;
    end else begin
      // a released bus never holds its last value
      errAddr <= ~errAddr;
      {errSynd0, errSynd1, errOctaword} <= ~{errSynd0, errSynd1, errOctaword};
    end
  end
endmodule // fill_source_model

// >>> tb/tb_fill_ecc_error_recovery.sv
`timescale 1ns/1ps
// drives error events through the far-side model and predicts every output
module tb_fill_ecc_error_recovery;
  // compare, count, report at once
  `define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

  int checked = 0; // comparisons made
  int n_mismatch = 0; // comparisons failed
  logic [31:0] rng = 32'h0000851d; // fixed seed keeps runs repeatable
  logic sys_clk, reset, send, crdEnable, mchkEnable, firmwareMode, statusClear;
  fill_ecc_pkg::err_src_t srcIn, errSource;
  logic [3:0] flagsIn; // memory, double, load use, speculative
  logic [fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::ADDR_LO] addrIn, errAddr, errorAddress, addrExp;
  logic [17:0] dataIn; // syndrome 0, syndrome 1, octaword
  logic errValid, errFromMemory, errDouble, errLoadUse, errSpeculative;
  logic [7:0] errSynd0, errSynd1, syndrome0, syndrome1;
  logic [1:0] errOctaword, badParityOctaword;
  logic correctedReadInterrupt, machineCheck, loadEccFlag, icacheFlush, badParityWrite;
  logic rawCacheWrite, rawRegisterWrite, loadQueueHold, replayTrap, mapStall;
  logic scrubEvict, scrubWriteBack, loadRetry, rawVictimToPort, rawProbeForward, flagExp;
  logic [15:0] syndExp; // expected syndrome pair
  fill_ecc_pkg::status_code_t cacheErrorStatus, stExp;

  fill_source_model i_far (.sys_clk, .reset, .send, .srcIn, .flagsIn, .addrIn, .dataIn,
    .errValid, .errSource, .errFromMemory, .errDouble, .errLoadUse, .errSpeculative,
    .errAddr, .errSynd0, .errSynd1, .errOctaword);

  fill_ecc_error_recovery i_dut (.sys_clk, .reset, .errValid, .errSource, .errFromMemory,
    .errDouble, .errLoadUse, .errSpeculative, .errAddr, .errSynd0, .errSynd1, .errOctaword,
    .crdEnable, .mchkEnable, .firmwareMode, .statusClear, .correctedReadInterrupt,
    .machineCheck, .cacheErrorStatus, .errorAddress, .syndrome0, .syndrome1, .loadEccFlag,
    .icacheFlush, .badParityWrite, .badParityOctaword, .rawCacheWrite, .rawRegisterWrite,
    .loadQueueHold, .replayTrap, .mapStall, .scrubEvict, .scrubWriteBack, .loadRetry,
    .rawVictimToPort, .rawProbeForward);

  // free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // xorshift generator
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // status after an event; none means the register keeps its value
  function automatic fill_ecc_pkg::status_code_t exp_status(fill_ecc_pkg::err_src_t s,
      logic [3:0] f);
    case (s)
      fill_ecc_pkg::SRC_IC_FILL: return f[2] ? (f[3] ? fill_ecc_pkg::INSTR_FILL_MEMORY_DOUBLE
        : fill_ecc_pkg::INSTR_FILL_BOARD_DOUBLE) : (f[3] ? fill_ecc_pkg::INSTR_FILL_MEMORY_SINGLE
        : fill_ecc_pkg::INSTR_FILL_BOARD_SINGLE);
      fill_ecc_pkg::SRC_DC_FILL: return f[2] ? (f[3] ? fill_ecc_pkg::DATA_FILL_MEMORY_DOUBLE
        : fill_ecc_pkg::DATA_FILL_BOARD_DOUBLE) : (f[1] && f[0]) ? fill_ecc_pkg::STATUS_NONE
        : (f[3] ? fill_ecc_pkg::DATA_FILL_MEMORY_SINGLE : fill_ecc_pkg::DATA_FILL_BOARD_SINGLE);
      fill_ecc_pkg::SRC_DC_LOAD: return f[0] ? fill_ecc_pkg::STATUS_NONE
        : fill_ecc_pkg::DATA_CACHE_LOAD_SINGLE;
      fill_ecc_pkg::SRC_PROBE: return fill_ecc_pkg::PROBE_HIT_SINGLE;
      default: return fill_ecc_pkg::STATUS_NONE;
    endcase
  endfunction

  // crd, check, flush, parity, raw cache, raw register, replay, victim, probe
  function automatic logic [8:0] exp_pulses(fill_ecc_pkg::err_src_t s, logic [3:0] f,
      logic c, logic m, logic fw);
    logic ic, dc, dbl;
    ic = s == fill_ecc_pkg::SRC_IC_FILL;
    dc = s == fill_ecc_pkg::SRC_DC_FILL;
    dbl = (ic || dc) && f[2];
    return {c && !dbl && s != fill_ecc_pkg::SRC_VICTIM_EVICT, m && (dbl ? !fw : ic),
      ic && !dbl, ic && !dbl, dbl ? f[3] : dc && !f[1], dc && !dbl && f[1],
      !dbl && !f[0] && ((dc && f[1]) || s == fill_ecc_pkg::SRC_DC_LOAD),
      s == fill_ecc_pkg::SRC_VICTIM_MISS || s == fill_ecc_pkg::SRC_VICTIM_EVICT,
      s == fill_ecc_pkg::SRC_PROBE};
  endfunction

  // one event, then the scrub walk and release of any deferred check
  task automatic event_run(fill_ecc_pkg::err_src_t s, logic [3:0] f, logic c, logic m,
      logic fw);
    fill_ecc_pkg::status_code_t st;
    logic [8:0] p;
    logic [3:0] nm;
    logic dbl;
    logic [fill_ecc_pkg::ADDR_HI:fill_ecc_pkg::ADDR_LO] a;
    logic [17:0] d;
    st = exp_status(s, f);
    p = exp_pulses(s, f, c, m, fw);
    dbl = f[2] && (s == fill_ecc_pkg::SRC_IC_FILL || s == fill_ecc_pkg::SRC_DC_FILL);
    a = 37'({xs(), xs()});
    d = 18'(xs());
    nm = 4'h0;
    @(posedge sys_clk);
    srcIn <= s;
    flagsIn <= f;
    addrIn <= a;
    dataIn <= d;
    crdEnable <= c;
    mchkEnable <= m;
    firmwareMode <= fw;
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    @(posedge sys_clk);
    #1;
    if (st != fill_ecc_pkg::STATUS_NONE) begin
      stExp = st;
      addrExp[19:6] = a[19:6];
      // load errors leave the high address bits alone
      if (s != fill_ecc_pkg::SRC_DC_LOAD) addrExp = a;
      if (!dbl && s != fill_ecc_pkg::SRC_DC_LOAD) syndExp = d[17:2];
    end
    flagExp = flagExp | p[2];
    `CHK("pulses", p, {correctedReadInterrupt, machineCheck, icacheFlush, badParityWrite,
      rawCacheWrite, rawRegisterWrite, replayTrap,
      rawVictimToPort, rawProbeForward})
    `CHK("status", stExp, cacheErrorStatus)
    `CHK("address", addrExp, errorAddress)
    `CHK("syndromes", syndExp, {syndrome0, syndrome1})
    `CHK("flag", flagExp, loadEccFlag)
    if (p[5]) `CHK("octaword", d[1:0], badParityOctaword)
    for (int k = 1; k < 6; k++) begin
      if (k > 1) begin
        @(posedge sys_clk);
        #1;
        nm = nm + 4'(machineCheck);
      end
      // the sequencer starts one cycle after the event, so nothing shows at k = 1
      `CHK("scrub", p[2] && k > 1 ? 4'h8 >> (k - 1) : 4'h0,
        {1'b0, scrubEvict, scrubWriteBack, loadRetry})
      `CHK("hold", {p[2] && k < 5, p[2] && k < 4}, {loadQueueHold, mapStall})
    end
    `CHK("held", 4'h0, nm)
    // native mode resumes; a held check must come out once
    @(posedge sys_clk);
    firmwareMode <= 1'b0;
    repeat (3) begin
      @(posedge sys_clk);
      #1;
      nm = nm + 4'(machineCheck);
    end
    `CHK("deferred", {3'h0, dbl && m && fw}, nm)
  endtask

  // clear pulse: status and flag drop
  task automatic clear_status();
    @(posedge sys_clk);
    statusClear <= 1'b1;
    @(posedge sys_clk);
    statusClear <= 1'b0;
    stExp = fill_ecc_pkg::STATUS_NONE;
    flagExp = 1'b0;
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // about 80 events of under 15 cycles each; ample margin before cutting a hang
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  // main sequence: corners first, then random traffic
  initial begin
    logic [31:0] r;
    reset = 1'b1;
    send = 1'b0;
    srcIn = fill_ecc_pkg::SRC_IC_FILL;
    {flagsIn, addrIn, dataIn} = '0;
    {crdEnable, mchkEnable, firmwareMode, statusClear} = 4'hc;
    stExp = fill_ecc_pkg::STATUS_NONE;
    {addrExp, syndExp, flagExp} = '0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("reset status", stExp, cacheErrorStatus)
    clear_status();
    event_run(fill_ecc_pkg::SRC_VICTIM_MISS, 4'h0, 1'b1, 1'b1, 1'b0);
    event_run(fill_ecc_pkg::SRC_VICTIM_EVICT, 4'h0, 1'b1, 1'b1, 1'b0);
    event_run(fill_ecc_pkg::SRC_DC_FILL, 4'h3, 1'b1, 1'b1, 1'b0);
    event_run(fill_ecc_pkg::SRC_DC_LOAD, 4'h1, 1'b1, 1'b1, 1'b0);
    // four double codes, each in native and firmware mode
    for (int i = 0; i < 8; i++) begin
      event_run(i[0] ? fill_ecc_pkg::SRC_DC_FILL : fill_ecc_pkg::SRC_IC_FILL,
        {i[1], 3'h4}, 1'b1, 1'b1, i[2]);
    end
    event_run(fill_ecc_pkg::SRC_IC_FILL, 4'h8, 1'b1, 1'b1, 1'b1);
    event_run(fill_ecc_pkg::SRC_DC_FILL, 4'ha, 1'b1, 1'b1, 1'b0);
    event_run(fill_ecc_pkg::SRC_DC_LOAD, 4'h0, 1'b0, 1'b0, 1'b0);
    event_run(fill_ecc_pkg::SRC_PROBE, 4'h0, 1'b0, 1'b0, 1'b0);
    clear_status();
    repeat (60) begin
      r = xs();
      event_run(fill_ecc_pkg::err_src_t'(3'(r % 6)), r[7:4], r[8] | r[9], r[10], r[11] & r[12]);
    end
    final_report();
  end
endmodule // tb_fill_ecc_error_recovery
